// File: logic/fsc_pkg.sv
/*
 fallback serial configuration: constants, register map, field layout,
 reset values and carrier types shared by the design.
 assumes a 250 MHz single clock and a classic wishbone register bus.
*/
// What this block does
// RULE1 - pin low forces 300 baud, 8N1
// RULE2 - fallback accepts any address character
// RULE3 - NULL, CR, dollar, hash never match
// RULE4 - host always sends an address character
// RULE5 - fallback entry leaves stored setup untouched
// RULE6 - setup readback returns stored values always
// RULE7 - every command stays enabled in fallback
// RULE8 - error reply is question mark, address
// RULE9 - fallback setup writes change stored values only
// RULE10 - pin release: program reset, stored link settings
// RULE11 - power-up applies stored channel directions; reset loads FSC_RST_DIR into both stored and live directions instead
// RULE12 - each channel independently input or output
// RULE13 - host uses fallback with one device only
// RULE14 - delivered setup: addr 1, 300, plain
// RULE15 - fallback pin synchronised and filtered
`default_nettype none
package fsc_pkg;
    // register byte offsets
    localparam logic [7:0] FSC_OFS_SETUP = 8'h00;
    localparam logic [7:0] FSC_OFS_DIR_STORED = 8'h04;
    localparam logic [7:0] FSC_OFS_DIR_LIVE = 8'h08;
    localparam logic [7:0] FSC_OFS_STATUS = 8'h0c;
    // setup word field positions
    localparam int FSC_POS_ADDR = 0;
    localparam int FSC_POS_BAUD = 8;
    localparam int FSC_POS_PAR = 11;
    localparam int FSC_POS_LF = 13;
    localparam int FSC_POS_ECHO = 14;
    localparam int FSC_POS_DLY = 15;
    // status word field positions
    localparam int FSC_POS_ST_FB = 0;
    localparam int FSC_POS_ST_BAUD = 1;
    localparam int FSC_POS_ST_PAR = 4;
    // codes
    localparam logic [2:0] FSC_BAUD_300 = 3'h0;
    localparam logic [1:0] FSC_PAR_NONE = 2'h0;
    localparam logic [7:0] FSC_CH_NULL = 8'h00;
    localparam logic [7:0] FSC_CH_CR = 8'h0d;
    localparam logic [7:0] FSC_CH_DOLLAR = 8'h24;
    localparam logic [7:0] FSC_CH_HASH = 8'h23;
    localparam logic [7:0] FSC_CH_PROMPT = 8'h3f;
    // delivered setup values
    localparam logic [7:0] FSC_RST_ADDR = 8'h31;
    localparam logic [2:0] FSC_RST_DLY = 3'h2;
    localparam logic [31:0] FSC_RST_DIR = 32'h0000_0000;
    // pin filter time
    localparam int FSC_CLK_MHZ = 250;
    localparam int FSC_FILT_NS = 1000;
    localparam int FSC_FILT_CYC = (FSC_FILT_NS * FSC_CLK_MHZ + 999) / 1000;
    localparam int FSC_MAX_CH = 32;

    typedef struct packed {
        logic [2:0] dly;
        logic echo;
        logic lf;
        logic [1:0] par;
        logic [2:0] baud;
        logic [7:0] addr;
    } fsc_setup_s;

    typedef struct packed {
        logic fallback;
        logic [1:0] par;
        logic [2:0] baud;
    } fsc_link_s;

    typedef enum logic [1:0] {
        FSC_ERR_IDLE,
        FSC_ERR_PROMPT,
        FSC_ERR_ADDR
    } fsc_err_e;

    typedef struct packed {
        logic [2:0] pin_sync;
        logic pin_level;
        logic [15:0] filt_cnt;
        logic prog_rst;
        fsc_setup_s setup;
        logic [31:0] dir_stored;
        logic [31:0] dir_live;
        fsc_link_s link;
        logic match;
        logic match_vld;
        fsc_err_e err_st;
        logic [7:0] resp_char;
        logic resp_vld;
        logic ack;
        logic [31:0] rdata;
    } fsc_state_s;
endpackage
`default_nettype wire

// File: logic/fsc_top.sv
/*
 fallback serial configuration block: stored link setup, fallback pin
 handling, address match, error prompt and channel direction control.
 assumes the uart, command parser and channel drivers sit outside and
 use the link settings, match result and directions given here.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_top
    import fsc_pkg::*;
#(
    parameter int NCH = 15
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // active low fallback pin
    input wire logic fallback_n_i,
    // address character check from the parser
    input wire logic [7:0] addr_char_i,
    input wire logic addr_vld_i,
    output logic addr_match_o,
    output logic addr_match_vld_o,
    // error reply characters to the transmitter
    input wire logic err_req_i,
    input wire logic resp_ready_i,
    output logic [7:0] resp_char_o,
    output logic resp_vld_o,
    // link settings and program reset
    output logic [2:0] link_baud_o,
    output logic [1:0] link_par_o,
    output logic link_fallback_o,
    output logic prog_rst_o,
    // applied channel directions, 1 = output
    output logic [NCH-1:0] ch_dir_o
);

    if (NCH < 1 || NCH > FSC_MAX_CH) begin : g_bad_nch
        $error("NCH must lie between 1 and 32");
    end

    localparam logic [15:0] FILT_LAST = 16'(FSC_FILT_CYC - 1);
    localparam logic [31:0] CH_MASK = 32'((64'h1 << NCH) - 64'h1);

    function automatic logic addr_legal(input logic [7:0] c);
        addr_legal = !(c == FSC_CH_NULL || c == FSC_CH_CR ||
                       c == FSC_CH_DOLLAR || c == FSC_CH_HASH);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        merge = res;
    endfunction

    function automatic logic [31:0] setup_word(input fsc_setup_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FSC_POS_ADDR +: 8] = s.addr;
        w[FSC_POS_BAUD +: 3] = s.baud;
        w[FSC_POS_PAR +: 2] = s.par;
        w[FSC_POS_LF] = s.lf;
        w[FSC_POS_ECHO] = s.echo;
        w[FSC_POS_DLY +: 3] = s.dly;
        setup_word = w;
    endfunction

    function automatic fsc_setup_s word_setup(input logic [31:0] w);
        fsc_setup_s s;
        s.addr = w[FSC_POS_ADDR +: 8];
        s.baud = w[FSC_POS_BAUD +: 3];
        s.par = w[FSC_POS_PAR +: 2];
        s.lf = w[FSC_POS_LF];
        s.echo = w[FSC_POS_ECHO];
        s.dly = w[FSC_POS_DLY +: 3];
        word_setup = s;
    endfunction

    fsc_state_s st_r;
    fsc_state_s st_nxt;

    logic bus_req;
    logic pin_agree;
    logic pin_seen;
    logic [31:0] status_word;

    assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
    // only the second and third stages are compared
    assign pin_agree = st_r.pin_sync[1] == st_r.pin_sync[2];
    assign pin_seen = st_r.pin_sync[2];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[FSC_POS_ST_FB] = st_r.link.fallback;
        status_word[FSC_POS_ST_BAUD +: 3] = st_r.link.baud;
        status_word[FSC_POS_ST_PAR +: 2] = st_r.link.par;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.prog_rst = 1'b0;
        st_nxt.match_vld = 1'b0;
        st_nxt.ack = bus_req;

        // three stage synchroniser, then a stability filter
        st_nxt.pin_sync = {st_r.pin_sync[1:0], fallback_n_i};
        if (pin_agree && pin_seen != st_r.pin_level) begin // [RULE15]
            if (st_r.filt_cnt == FILT_LAST) begin
                st_nxt.filt_cnt = 16'h0000;
                st_nxt.pin_level = pin_seen;
                if (pin_seen) begin
                    // release: restart with the stored link settings
                    st_nxt.prog_rst = 1'b1; // [RULE10]
                end
            end else begin
                st_nxt.filt_cnt = st_r.filt_cnt + 16'h0001;
            end
        end else begin
            st_nxt.filt_cnt = 16'h0000;
        end

        // link settings: forced while the filtered pin is low
        if (!st_r.pin_level) begin
            st_nxt.link.fallback = 1'b1;
            st_nxt.link.baud = FSC_BAUD_300; // [RULE1] [RULE9]
            st_nxt.link.par = FSC_PAR_NONE; // [RULE1] [RULE9]
        end else begin
            st_nxt.link.fallback = 1'b0;
            st_nxt.link.baud = st_r.setup.baud; // [RULE10]
            st_nxt.link.par = st_r.setup.par; // [RULE10]
        end

        // address check; fallback takes any legal character
        if (addr_vld_i) begin
            st_nxt.match_vld = 1'b1;
            // fallback gates nothing else, all commands stay usable [RULE7]
            if (!addr_legal(addr_char_i)) begin
                st_nxt.match = 1'b0; // [RULE3]
            end else if (st_r.link.fallback) begin
                st_nxt.match = 1'b1; // [RULE2]
            end else begin
                st_nxt.match = addr_char_i == st_r.setup.addr;
            end
        end

        // error reply: prompt then the stored address character
        case (st_r.err_st)
            FSC_ERR_IDLE: begin
                if (err_req_i && !st_r.prog_rst) begin
                    st_nxt.err_st = FSC_ERR_PROMPT;
                    st_nxt.resp_char = FSC_CH_PROMPT; // [RULE8]
                    st_nxt.resp_vld = 1'b1;
                end
            end
            FSC_ERR_PROMPT: begin
                if (resp_ready_i) begin
                    st_nxt.err_st = FSC_ERR_ADDR;
                    st_nxt.resp_char = st_r.setup.addr; // [RULE8]
                end
            end
            FSC_ERR_ADDR: begin
                if (resp_ready_i) begin
                    st_nxt.err_st = FSC_ERR_IDLE;
                    st_nxt.resp_vld = 1'b0;
                end
            end
            default: begin
                st_nxt.err_st = FSC_ERR_IDLE;
                st_nxt.resp_vld = 1'b0;
            end
        endcase

        // program reset reapplies stored directions; after the reply
        // machine so a reply in flight cannot outlive the reset
        if (st_r.prog_rst) begin
            st_nxt.dir_live = st_r.dir_stored & CH_MASK; // [RULE10] [RULE11]
            st_nxt.err_st = FSC_ERR_IDLE;
            st_nxt.resp_vld = 1'b0;
        end

        // register bus; unmapped reads return zero, writes are dropped
        st_nxt.rdata = 32'h0000_0000;
        if (bus_req) begin
            case (wb_adr_i)
                FSC_OFS_SETUP: begin
                    // stored values, never the forced link values [RULE6]
                    st_nxt.rdata = setup_word(st_r.setup);
                    if (wb_we_i) begin
                        // stored copy only; link is steered above [RULE9]
                        st_nxt.setup = word_setup(
                            merge(setup_word(st_r.setup), wb_dat_i, wb_sel_i));
                    end
                end
                FSC_OFS_DIR_STORED: begin
                    st_nxt.rdata = st_r.dir_stored;
                    if (wb_we_i) begin
                        st_nxt.dir_stored =
                            merge(st_r.dir_stored, wb_dat_i, wb_sel_i) & CH_MASK;
                    end
                end
                FSC_OFS_DIR_LIVE: begin
                    st_nxt.rdata = st_r.dir_live;
                    if (wb_we_i && !st_r.prog_rst) begin
                        // one bit per channel, independent [RULE12]
                        st_nxt.dir_live =
                            merge(st_r.dir_live, wb_dat_i, wb_sel_i) & CH_MASK;
                    end
                end
                FSC_OFS_STATUS: begin
                    st_nxt.rdata = status_word;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.pin_sync <= 3'h7;
            st_r.pin_level <= 1'b1;
            st_r.filt_cnt <= 16'h0000;
            st_r.prog_rst <= 1'b0;
            // stored setup as delivered; the pin never touches it [RULE14] [RULE5]
            st_r.setup.addr <= FSC_RST_ADDR;
            st_r.setup.baud <= FSC_BAUD_300;
            st_r.setup.par <= FSC_PAR_NONE;
            st_r.setup.lf <= 1'b0;
            st_r.setup.echo <= 1'b0;
            st_r.setup.dly <= FSC_RST_DLY;
            st_r.dir_stored <= FSC_RST_DIR;
            // power-up loads FSC_RST_DIR, not the earlier stored directions, which reset also clears [RULE11]
            st_r.dir_live <= FSC_RST_DIR;
            st_r.link.fallback <= 1'b0;
            st_r.link.baud <= FSC_BAUD_300;
            st_r.link.par <= FSC_PAR_NONE;
            st_r.match <= 1'b0;
            st_r.match_vld <= 1'b0;
            st_r.err_st <= FSC_ERR_IDLE;
            st_r.resp_char <= 8'h00;
            st_r.resp_vld <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign addr_match_o = st_r.match;
    assign addr_match_vld_o = st_r.match_vld;
    assign resp_char_o = st_r.resp_char;
    assign resp_vld_o = st_r.resp_vld;
    assign link_baud_o = st_r.link.baud;
    assign link_par_o = st_r.link.par;
    assign link_fallback_o = st_r.link.fallback;
    assign prog_rst_o = st_r.prog_rst;
    assign ch_dir_o = st_r.dir_live[NCH-1:0];

endmodule
`default_nettype wire

// File: testbench/fsc_top_sva.sv
/*
 checker on the fsc_top ports: bus answer, address check, reply, link.
 assumes binding onto fsc_top; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_top_sva
    import fsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [7:0] addr_char_i,
    input wire logic addr_vld_i,
    input wire logic addr_match_o,
    input wire logic addr_match_vld_o,
    input wire logic err_req_i,
    input wire logic resp_ready_i,
    input wire logic [7:0] resp_char_o,
    input wire logic resp_vld_o,
    input wire logic [2:0] link_baud_o,
    input wire logic [1:0] link_par_o,
    input wire logic link_fallback_o,
    input wire logic prog_rst_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rsv;
    assign rsv = addr_char_i inside {FSC_CH_NULL, FSC_CH_CR, FSC_CH_DOLLAR, FSC_CH_HASH};
    sequence s_err_start;
        err_req_i && !resp_vld_o && !prog_rst_o;
    endsequence
    sequence s_prompt_taken;
        resp_vld_o && resp_ready_i && resp_char_o == FSC_CH_PROMPT;
    endsequence
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_check_answer: assert property (addr_vld_i |=> addr_match_vld_o)
        else $error("address check gave no answer");
    a_reserved_nomatch: assert property (addr_vld_i && rsv |=> !addr_match_o)
        else $error("reserved character matched");
    a_fallback_any: assert property (
        addr_vld_i && !rsv && link_fallback_o ##1 link_fallback_o |-> addr_match_o)
        else $error("fallback refused a legal character");
    a_fallback_slow: assert property (
        link_fallback_o |-> link_baud_o == FSC_BAUD_300 && link_par_o == FSC_PAR_NONE)
        else $error("fallback link not 300 no parity");
    a_err_prompt: assert property (
        s_err_start |=> resp_vld_o && resp_char_o == FSC_CH_PROMPT)
        else $error("error reply did not open with prompt");
    a_reply_ends: assert property (
        s_prompt_taken ##1 (resp_vld_o && resp_ready_i) |=> !resp_vld_o)
        else $error("reply longer than two characters");
    a_char_holds: assert property (
        resp_vld_o && !resp_ready_i && !prog_rst_o |=> resp_vld_o && $stable(resp_char_o))
        else $error("reply character dropped before taken");
    a_release_reset: assert property (
        prog_rst_o |-> link_fallback_o ##1 !link_fallback_o && !prog_rst_o)
        else $error("program reset not tied to release");
endmodule
bind fsc_top fsc_top_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .addr_char_i,
    .addr_vld_i, .addr_match_o, .addr_match_vld_o, .err_req_i, .resp_ready_i, .resp_char_o,
    .resp_vld_o, .link_baud_o, .link_par_o, .link_fallback_o, .prog_rst_o);
`default_nettype wire

// File: testbench/fsc_host_model.sv
/*
 host terminal model: takes reply characters, fast or stalling.
 assumes one device alone on the link.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic resp_vld_i,
    input wire logic [7:0] resp_char_i,
    output logic resp_ready_o,
    output logic [15:0] reply_o
);
    // slow host takes every other cycle so the reply must hold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_ready_o <= 1'h0;
            reply_o <= 16'h0000;
        end else begin
            resp_ready_o <= slow_i ? !resp_ready_o : 1'h1;
            if (resp_vld_i && resp_ready_o) begin
                reply_o <= {reply_o[7:0], resp_char_i};
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/fsc_tb_top.sv
/*
 self-checking bench for fsc_top: rows of address checks, then setup,
 reply and pin release cases. assumes fsc_top with NCH of 15.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_tb_top
    import fsc_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, err_req = 1'h0, addr_vld = 1'h0;
    logic fb_n = 1'h1, slow = 1'h0, pr, ack, mv, m, rv, rdy, fb, prst;
    logic [7:0] wb_adr = 8'h00, ach = 8'h00, rc;
    logic [31:0] wb_dat = 32'h0000_0000, rd, dat_o;
    logic [3:0] wb_sel = 4'hf;
    logic [2:0] baud;
    logic [1:0] par;
    logic [14:0] dir;
    logic [15:0] reply;
    logic [9:0] rows [10] = '{{1'h0, 8'h31, 1'h1}, {1'h0, 8'h32, 1'h0}, {1'h0, 8'h00, 1'h0},
        {1'h0, 8'h0d, 1'h0}, {1'h1, 8'h32, 1'h1}, {1'h1, 8'h41, 1'h1}, {1'h1, 8'h00, 1'h0},
        {1'h1, 8'h0d, 1'h0}, {1'h1, 8'h24, 1'h0}, {1'h1, 8'h23, 1'h0}};
    int n_errors = 0, checks = 0, n;
    always #2 clk_i = ~clk_i;
    fsc_top u_dut (.clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fallback_n_i(fb_n), .addr_char_i(ach), .addr_vld_i(addr_vld), .addr_match_o(m),
        .addr_match_vld_o(mv), .err_req_i(err_req), .resp_ready_i(rdy), .resp_char_o(rc),
        .resp_vld_o(rv), .link_baud_o(baud), .link_par_o(par), .link_fallback_o(fb),
        .prog_rst_o(prst), .ch_dir_o(dir));
    fsc_host_model u_host (.clk_i, .rst_i, .slow_i(slow), .resp_vld_i(rv), .resp_char_i(rc),
        .resp_ready_o(rdy), .reply_o(reply));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic timed_out(input string nm);
        n_errors++;
        $display("BAD %s expected answer seen none", nm);
        complete_run();
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        rd = dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (n >= 20) timed_out("wb_ack_o");
        @(posedge clk_i);
    endtask
    task automatic check_addr(input logic [7:0] c, input logic exp);
        ach <= c;
        addr_vld <= 1'h1;
        @(posedge clk_i);
        addr_vld <= 1'h0;
        @(posedge clk_i);
        chk("addr_match_vld_o", {31'h0, mv}, 32'h1);
        chk("addr_match_o", {31'h0, m}, {31'h0, exp});
    endtask
    // pr catches the one-cycle program reset seen while waiting
    task automatic set_pin(input logic v);
        fb_n <= v;
        pr = 1'h0;
        n = 0;
        do begin
            @(posedge clk_i);
            pr |= (prst === 1'h1);
            n++;
        end while (fb !== !v && n < 400);
        if (n >= 400) timed_out("link_fallback_o");
    endtask
    // one error reply, waited for until the host holds prompt and address
    task automatic err_reply(input logic [7:0] a);
        err_req <= 1'h1;
        @(posedge clk_i);
        err_req <= 1'h0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (reply !== {FSC_CH_PROMPT, a} && n < 20);
        if (n >= 20) timed_out("resp_vld_o");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb(1'h0, FSC_OFS_SETUP, 32'h0);
        chk("setup reset", rd, 32'h0001_0031);
        wb(1'h0, 8'h10, 32'h0);
        chk("unmapped read", rd, 32'h0);
        fb_n <= 1'h0;
        repeat (50) @(posedge clk_i);
        fb_n <= 1'h1;
        repeat (300) @(posedge clk_i);
        chk("glitch", {31'h0, fb}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i][9] !== fb) set_pin(!rows[i][9]);
            check_addr(rows[i][8:1], rows[i][0]);
        end
        wb(1'h0, FSC_OFS_STATUS, 32'h0);
        chk("status", rd, 32'h1);
        wb(1'h0, FSC_OFS_SETUP, 32'h0);
        chk("setup kept", rd, 32'h0001_0031);
        wb(1'h1, FSC_OFS_SETUP, 32'h0001_0b32);
        wb(1'h0, FSC_OFS_SETUP, 32'h0);
        chk("setup read", rd, 32'h0001_0b32);
        chk("fallback link", {26'h0, fb, par, baud}, 32'h20);
        wb(1'h1, FSC_OFS_DIR_STORED, 32'h0000_5555);
        slow <= 1'h1;
        err_reply(8'h32);
        chk("reply", {16'h0, reply}, {16'h0, FSC_CH_PROMPT, 8'h32});
        set_pin(1'h1);
        chk("prog_rst_o", {31'h0, pr}, 32'h1);
        chk("stored link", {26'h0, fb, par, baud}, 32'hb);
        chk("ch_dir_o", {17'h0, dir}, 32'h5555);
        wb_sel <= 4'h1;
        wb(1'h1, FSC_OFS_DIR_LIVE, 32'h0000_ffff);
        wb_sel <= 4'hf;
        chk("ch_dir_o byte", {17'h0, dir}, 32'h55ff);
        wb(1'h0, FSC_OFS_DIR_LIVE, 32'h0);
        chk("dir live read", rd, 32'h55ff);
        check_addr(8'h32, 1'h1);
        check_addr(8'h31, 1'h0);
        // power-up again in mid-run: delivered setup, delivered all-zero directions applied
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("ch_dir_o reset", {17'h0, dir}, 32'h0);
        wb(1'h0, FSC_OFS_SETUP, 32'h0);
        chk("setup after reset", rd, 32'h0001_0031);
        slow <= 1'h0;
        err_reply(FSC_RST_ADDR);
        chk("fast reply", {16'h0, reply}, {16'h0, FSC_CH_PROMPT, FSC_RST_ADDR});
        complete_run();
    end
endmodule
`default_nettype wire
